// ---- verilog/usm_port.sv ----
// usm_port: master-only synchronous serial port with an AHB-Lite register slave
//
// Functional notes
// - bit rate is fclk over 2(divider+1)
// - divider from high and low bytes, 0-4095
// - polarity and phase pick four sampling modes
// - changing format mid-frame corrupts, unprotected
// - eight bits, order setting shared by both
// - next frame follows at once, else high
// - two writes give back-to-back sixteen bits
// - divider resets to zero
// - transfers need transmitter; receiver cannot run alone
// - enables take over data pins; clock pin used
// - data register write starts every transfer
// - written byte waits, then loads shift register
// - overflow drops newest byte, keeps older
// - framing, overrun, parity flags read zero
// - mode field both ones selects master mode
// - complete flag: frame done, buffer empty; w1c
// - empty flag set when buffer free, at reset
// - receiver off flushes; transmitter off waits empty
//
// Chosen here: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
module usm_port
  import usm_pkg::*;
#(
  parameter int ADDR_W = 8,             // decoded address bits
  parameter int RX_DEPTH = USM_RX_DEPTH // receive buffer entries
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // ahb-lite slave
  input wire logic hsel_i,
  input wire logic [ADDR_W-1:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // serial pins
  output logic serial_clock_pin_o,     // transfer clock, idles at polarity
  output logic serial_data_out_pin_o,  // shifted data, idles high
  output logic serial_data_out_pin_oe_o, // high while the transmitter owns the pin
  input wire logic serial_data_in_pin_i,
  output logic serial_data_in_owned_o  // high while the receiver owns the pin
);

  localparam int PTR_W = (RX_DEPTH > 1) ? $clog2(RX_DEPTH) : 1;
  localparam int CNT_W = $clog2(RX_DEPTH + 1);
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(RX_DEPTH - 1);
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(RX_DEPTH);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  // bus data phase bookkeeping
  logic wr_pending;             // write data phase in progress
  logic [ADDR_W-1:0] wr_addr;   // address of that write
  logic bus_take;               // address phase accepted this cycle
  logic rd_take;                // read accepted this cycle
  logic [31:0] next_rdata;      // read mux result
  // software registers
  logic rx_en;                  // receiver_enable
  logic tx_en;                  // transmitter_enable as written
  logic tx_on;                  // transmitter effectively running
  logic [1:0] port_mode_select; // mode field
  logic bit_order_select;       // one sends lsb first
  logic clock_phase_bit;
  logic clock_polarity_bit;
  logic [USM_RATE_W-1:0] rate_divider;
  logic txc;                    // transmit_complete_flag
  // transmit buffer
  logic [7:0] tx_buf;
  logic tx_full;                // inverse of the empty flag
  // shift engine
  usm_state_t state;
  logic [3:0] edge_cnt;         // edge within the frame
  logic [3:0] bit_cnt;          // data bit within the frame
  logic [7:0] tx_shift;         // frame being sent
  logic [7:0] rx_shift;         // frame being received
  logic frame_done;             // pulse the cycle after the last edge
  logic tick;                   // edge enable from the divider
  logic master_mode;            // field selects master operation
  logic can_start;              // a byte is ready and the port may run
  logic last_tick;              // final edge of a frame
  logic load;                   // buffer moves into shift register
  logic sample_edge;            // this edge samples rather than sets up
  // receive buffer
  logic [7:0] rx_mem [RX_DEPTH];
  logic [PTR_W-1:0] rx_wr_ptr;
  logic [PTR_W-1:0] rx_rd_ptr;
  logic [CNT_W-1:0] rx_count;
  logic rx_push;
  logic rx_pop;

  // ----------------------------------------------------------------
  // bit selection for either order
  // ----------------------------------------------------------------
  function automatic logic [2:0] bit_pos(input logic [3:0] idx, input logic lsb_first);
    logic [2:0] pos;
    pos = idx[2:0];
    if (!lsb_first) begin
      pos = 3'h7 - idx[2:0]; // msb first walks down
    end
    return pos;
  endfunction : bit_pos

  // ----------------------------------------------------------------
  // bus handshake
  // ----------------------------------------------------------------
  assign bus_take = hsel_i && hready_i && htrans_i[1];
  assign rd_take = bus_take && !hwrite_i;

  // zero wait states, always okay; hsize is accepted as a whole word
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end else begin
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end
  end

  // latch the write address; data follows in the next cycle
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      wr_pending <= 1'b0;
      wr_addr <= '0;
    end else begin
      wr_pending <= bus_take && hwrite_i;
      if (bus_take) begin
        wr_addr <= haddr_i;
      end
    end
  end

  // read mux; unmapped offsets read as zero
  always_comb begin
    next_rdata = '0;
    if (haddr_i == ADDR_W'(USM_ADDR_DATA)) begin
      next_rdata[7:0] = rx_mem[rx_rd_ptr];
    end else if (haddr_i == ADDR_W'(USM_ADDR_STATUS)) begin
      next_rdata[USM_ST_RXC] = (rx_count != '0);
      next_rdata[USM_ST_TXC] = txc;
      next_rdata[USM_ST_UDRE] = !tx_full;
      next_rdata[USM_ST_FE] = 1'b0;
      next_rdata[USM_ST_DOR] = 1'b0;
      next_rdata[USM_ST_PE] = 1'b0;
    end else if (haddr_i == ADDR_W'(USM_ADDR_CTRL_B)) begin
      next_rdata[USM_CB_RXEN] = rx_en;
      next_rdata[USM_CB_TXEN] = tx_en;
    end else if (haddr_i == ADDR_W'(USM_ADDR_CTRL_C)) begin
      next_rdata[USM_CC_MSEL_HI:USM_CC_MSEL_LO] = port_mode_select;
      next_rdata[USM_CC_ORDER] = bit_order_select;
      next_rdata[USM_CC_PHASE] = clock_phase_bit;
      next_rdata[USM_CC_POL] = clock_polarity_bit;
    end else if (haddr_i == ADDR_W'(USM_ADDR_RATE_LO)) begin
      next_rdata[7:0] = rate_divider[7:0];
    end else if (haddr_i == ADDR_W'(USM_ADDR_RATE_HI)) begin
      next_rdata[USM_RATE_HI_W-1:0] = rate_divider[USM_RATE_W-1:8];
    end
  end

  // read data is captured at the address phase so it comes from a flop
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      hrdata_o <= '0;
    end else if (rd_take) begin
      hrdata_o <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  // mode, format and enables; no guard against mid-frame changes
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rx_en <= 1'b0;
      tx_en <= 1'b0;
      port_mode_select <= '0;
      bit_order_select <= 1'b0;
      clock_phase_bit <= 1'b0;
      clock_polarity_bit <= 1'b0;
    end else if (wr_pending) begin
      if (wr_addr == ADDR_W'(USM_ADDR_CTRL_B)) begin
        rx_en <= hwdata_i[USM_CB_RXEN];
        tx_en <= hwdata_i[USM_CB_TXEN];
      end else if (wr_addr == ADDR_W'(USM_ADDR_CTRL_C)) begin
        port_mode_select <= hwdata_i[USM_CC_MSEL_HI:USM_CC_MSEL_LO];
        bit_order_select <= hwdata_i[USM_CC_ORDER];
        clock_phase_bit <= hwdata_i[USM_CC_PHASE];
        clock_polarity_bit <= hwdata_i[USM_CC_POL];
      end
    end
  end

  // divider halves, reset to zero
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rate_divider <= USM_RATE_RESET;
    end else if (wr_pending) begin
      if (wr_addr == ADDR_W'(USM_ADDR_RATE_LO)) begin
        rate_divider[7:0] <= hwdata_i[7:0];
      end else if (wr_addr == ADDR_W'(USM_ADDR_RATE_HI)) begin
        rate_divider[USM_RATE_W-1:8] <= hwdata_i[USM_RATE_HI_W-1:0];
      end
    end
  end

  assign master_mode = (port_mode_select == USM_MODE_MASTER_SERIAL);

  // transmitter turns on at once but only lets go once fully drained
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      tx_on <= 1'b0;
    end else if (tx_en) begin
      tx_on <= 1'b1;
    end else if (state == USM_IDLE && !tx_full) begin
      tx_on <= 1'b0;
    end
  end

  // pin ownership follows the effective enables
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      serial_data_out_pin_oe_o <= 1'b0;
      serial_data_in_owned_o <= 1'b0;
    end else begin
      serial_data_out_pin_oe_o <= tx_on;
      serial_data_in_owned_o <= rx_en;
    end
  end

  // ----------------------------------------------------------------
  // transmit buffer
  // ----------------------------------------------------------------
  // a write while the buffer is full, disabled or in another mode is dropped
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      tx_buf <= '0;
      tx_full <= 1'b0;
    end else if (wr_pending && wr_addr == ADDR_W'(USM_ADDR_DATA) && !tx_full
                 && tx_on && master_mode) begin
      tx_buf <= hwdata_i[7:0];
      tx_full <= 1'b1;
    end else if (load) begin
      tx_full <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // shift engine
  // ----------------------------------------------------------------
  assign can_start = tx_full && tx_on && master_mode;
  assign last_tick = (state == USM_SHIFT) && tick && (edge_cnt == USM_LAST_EDGE);
  assign load = can_start && ((state == USM_IDLE) || last_tick);
  // even edges lead; phase zero samples on the leading edge
  assign sample_edge = (edge_cnt[0] == clock_phase_bit);

  usm_rate_gen #(
    .RATE_W(USM_RATE_W)
  ) u_rate (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .run_i(state == USM_SHIFT),
    .divisor_i(rate_divider),
    .tick_o(tick)
  );

  // one frame is sixteen clock edges; bits move on alternate edges
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state <= USM_IDLE;
      serial_clock_pin_o <= 1'b0;
      serial_data_out_pin_o <= 1'b1;
      edge_cnt <= '0;
      bit_cnt <= '0;
      tx_shift <= '0;
      rx_shift <= '0;
      frame_done <= 1'b0;
    end else begin
      frame_done <= last_tick;
      case (state)
        USM_IDLE: begin
          serial_clock_pin_o <= clock_polarity_bit;
          serial_data_out_pin_o <= 1'b1;
        end
        USM_SHIFT: begin
          if (tick) begin
            serial_clock_pin_o <= ~serial_clock_pin_o;
            edge_cnt <= edge_cnt + 1'b1;
            if (sample_edge) begin
              rx_shift[bit_pos(bit_cnt, bit_order_select)] <= serial_data_in_pin_i;
              if (clock_phase_bit) begin
                bit_cnt <= bit_cnt + 1'b1;
              end
            end else if (clock_phase_bit) begin
              serial_data_out_pin_o <= tx_shift[bit_pos(bit_cnt, bit_order_select)];
            end else begin
              bit_cnt <= bit_cnt + 1'b1;
              serial_data_out_pin_o <= tx_shift[bit_pos(bit_cnt + 1'b1, bit_order_select)];
            end
            if (last_tick && !can_start) begin
              state <= USM_IDLE; // line goes high once idle, never on a sample edge
            end
          end
        end
        default: begin
          state <= USM_IDLE;
        end
      endcase
      // start a frame from idle or straight after the previous one
      if (load) begin
        state <= USM_SHIFT;
        tx_shift <= tx_buf;
        edge_cnt <= '0;
        bit_cnt <= '0;
        if (!clock_phase_bit) begin
          // phase zero samples on the first edge, so the bit goes out now
          serial_data_out_pin_o <= tx_buf[bit_pos('0, bit_order_select)];
        end
      end
    end
  end

  // complete flag: set wins over a same-cycle write-one clear
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      txc <= 1'b0;
    end else if (last_tick && !tx_full) begin
      txc <= 1'b1;
    end else if (wr_pending && wr_addr == ADDR_W'(USM_ADDR_STATUS)
                 && hwdata_i[USM_ST_TXC]) begin
      txc <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // receive buffer
  // ----------------------------------------------------------------
  // a full buffer drops the newest byte, older bytes stay readable
  assign rx_push = frame_done && rx_en && (rx_count != CNT_FULL);
  assign rx_pop = rd_take && haddr_i == ADDR_W'(USM_ADDR_DATA) && (rx_count != '0);

  // storage; each entry written only when the write pointer names it
  generate
    for (genvar i = 0; i < RX_DEPTH; i++) begin : g_rx
      always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
          rx_mem[i] <= '0;
        end else if (rx_push && rx_wr_ptr == PTR_W'(i)) begin
          rx_mem[i] <= rx_shift;
        end
      end
    end
  endgenerate

  // pointers and count; disabling the receiver empties it
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rx_wr_ptr <= '0;
      rx_rd_ptr <= '0;
      rx_count <= '0;
    end else if (!rx_en) begin
      rx_wr_ptr <= '0;
      rx_rd_ptr <= '0;
      rx_count <= '0;
    end else begin
      if (rx_push) begin
        rx_wr_ptr <= (rx_wr_ptr == PTR_LAST) ? '0 : rx_wr_ptr + 1'b1;
      end
      if (rx_pop) begin
        rx_rd_ptr <= (rx_rd_ptr == PTR_LAST) ? '0 : rx_rd_ptr + 1'b1;
      end
      if (rx_push && !rx_pop) begin
        rx_count <= rx_count + 1'b1;
      end else if (rx_pop && !rx_push) begin
        rx_count <= rx_count - 1'b1;
      end
    end
  end

endmodule : usm_port

// ---- verilog/usm_pkg.sv ----
// usm_pkg: shared constants and types for the master-mode serial port
package usm_pkg;

  // ----------------------------------------------------------------
  // register byte offsets on the bus
  // ----------------------------------------------------------------
  localparam logic [7:0] USM_ADDR_DATA = 8'h00;    // data_register: tx write, rx read
  localparam logic [7:0] USM_ADDR_STATUS = 8'h04;  // complete and empty flags
  localparam logic [7:0] USM_ADDR_CTRL_B = 8'h08;  // receiver and transmitter enables
  localparam logic [7:0] USM_ADDR_CTRL_C = 8'h0c;  // mode, order, phase, polarity
  localparam logic [7:0] USM_ADDR_RATE_LO = 8'h10; // rate_divider low byte
  localparam logic [7:0] USM_ADDR_RATE_HI = 8'h14; // rate_divider high nibble

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int USM_ST_RXC = 7;    // receive_complete_flag
  localparam int USM_ST_TXC = 6;    // transmit_complete_flag, write one to clear
  localparam int USM_ST_UDRE = 5;   // tx_buffer_empty_flag
  localparam int USM_ST_FE = 4;     // framing_error_flag, always zero here
  localparam int USM_ST_DOR = 3;    // overrun_flag, always zero here
  localparam int USM_ST_PE = 2;     // parity_error_flag, always zero here
  localparam int USM_CB_RXEN = 4;   // receiver_enable
  localparam int USM_CB_TXEN = 3;   // transmitter_enable
  localparam int USM_CC_MSEL_HI = 7; // port_mode_select upper bit
  localparam int USM_CC_MSEL_LO = 6; // port_mode_select lower bit
  localparam int USM_CC_ORDER = 2;  // bit_order_select, one is lsb first
  localparam int USM_CC_PHASE = 1;  // clock_phase_bit
  localparam int USM_CC_POL = 0;    // clock_polarity_bit
  localparam int USM_RATE_HI_W = 4; // bits of the divider held in the high register

  // ----------------------------------------------------------------
  // encodings, sizes and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] USM_MODE_MASTER_SERIAL = 2'h3; // master_serial_mode
  localparam logic [1:0] USM_HTRANS_NONSEQ = 2'h2;
  localparam int USM_RATE_W = 12;       // divider covers 0 to 4095
  localparam int USM_FRAME_BITS = 8;    // data bits per frame
  localparam int USM_RX_DEPTH = 2;      // receive buffer entries
  localparam logic [11:0] USM_RATE_RESET = 12'h000;
  localparam logic [3:0] USM_LAST_EDGE = 4'hf; // sixteen clock edges per frame

  // engine state
  typedef enum logic [0:0] {
    USM_IDLE,
    USM_SHIFT
  } usm_state_t;

endpackage : usm_pkg

// ---- verilog/usm_rate_gen.sv ----
// usm_rate_gen: divider that paces serial clock edges from the system clock
`timescale 1ns/10ps
module usm_rate_gen
  import usm_pkg::*;
#(
  parameter int RATE_W = USM_RATE_W
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // control
  input wire logic run_i,                  // frame in progress
  input wire logic [RATE_W-1:0] divisor_i, // rate_divider value
  // enable out
  output logic tick_o                      // one-cycle pulse per clock edge
);

  logic [RATE_W-1:0] count; // cycles left before the next edge

  // ----------------------------------------------------------------
  // countdown: an edge every divisor+1 cycles, so one bit spans
  // 2*(divisor+1) cycles; the count restarts whenever the engine idles
  // so the first edge of a frame always gets a full half period
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      count <= '0;
      tick_o <= 1'b0;
    end else if (!run_i) begin
      count <= divisor_i; // held ready while idle
      tick_o <= 1'b0;
    end else if (count == '0) begin
      count <= divisor_i;
      tick_o <= 1'b1;
    end else begin
      count <= count - 1'b1;
      tick_o <= 1'b0;
    end
  end

endmodule : usm_rate_gen

// ---- verif/usm_port_props.sv ----
// usm_port_props: bound checker for the serial port's bus and pin behaviour
`timescale 1ns/10ps
module usm_port_props
  import usm_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // clock, reset and bus
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic hsel_i,
  input wire logic [ADDR_W-1:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  // serial pins
  input wire logic serial_clock_pin_o,
  input wire logic serial_data_out_pin_o,
  input wire logic serial_data_out_pin_oe_o,
  input wire logic serial_data_in_owned_o
);
  // ----------------------------------------------------------------
  // request decode
  // ----------------------------------------------------------------
  logic take; // a transfer is taken at this edge
  logic rd; // a read is taken
  logic wr_enables; // a write to the enable register is taken
  assign take = hsel_i && hready_i && htrans_i[1];
  assign rd = take && !hwrite_i;
  assign wr_enables = take && hwrite_i && haddr_i == ADDR_W'(USM_ADDR_CTRL_B);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  resp_always_okay_a: assert property (hresp_o == 1'b0)
    else $error("bus response was not okay");
  ready_no_wait_a: assert property (hreadyout_o == 1'b1)
    else $error("slave inserted a wait state");
  status_err_zero_a: assert property (
    rd && haddr_i == ADDR_W'(USM_ADDR_STATUS) |=> hrdata_o[4:2] == 3'h0)
    else $error("error flags read nonzero");
  unmapped_read_zero_a: assert property (
    rd && haddr_i >= ADDR_W'(8'h18) |=> hrdata_o == 32'h0)
    else $error("unmapped read returned data");
  tx_own_on_a: assert property (
    wr_enables ##1 hwdata_i[USM_CB_TXEN] |-> ##3 serial_data_out_pin_oe_o)
    else $error("transmitter did not take the data pin");
  rx_own_follows_a: assert property (
    wr_enables ##2 1'b1 |=> serial_data_in_owned_o == $past(hwdata_i[USM_CB_RXEN], 2))
    else $error("receiver ownership did not follow enable");
  tx_own_cause_a: assert property (
    $rose(serial_data_out_pin_oe_o) |-> $past(wr_enables, 4))
    else $error("pin taken without an enable write");
  dout_idle_high_a: assert property (
    !serial_data_out_pin_oe_o |-> serial_data_out_pin_o)
    else $error("released data line not high");
  // main scenarios reached
  rx_enabled_c: cover property (wr_enables ##1 hwdata_i[USM_CB_RXEN]);
  tx_owned_c: cover property ($rose(serial_data_out_pin_oe_o));
  clock_moves_c: cover property (serial_data_out_pin_oe_o && $changed(serial_clock_pin_o));
endmodule : usm_port_props

bind usm_port usm_port_props #(.ADDR_W(ADDR_W)) usm_port_props_inst (
  .clock_i(clock_i), .rst_i(rst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
  .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hwdata_i(hwdata_i), .hready_i(hready_i),
  .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
  .serial_clock_pin_o(serial_clock_pin_o), .serial_data_out_pin_o(serial_data_out_pin_o),
  .serial_data_out_pin_oe_o(serial_data_out_pin_oe_o),
  .serial_data_in_owned_o(serial_data_in_owned_o));

// ---- verif/usm_spi_slave_model.sv ----
// usm_spi_slave_model: far-side serial peripheral that answers with a reply byte
`timescale 1ns/10ps
module usm_spi_slave_model (
  // serial pins
  input wire logic sck_i,
  input wire logic mosi_i,
  output logic miso_o,
  // bench control; clear stands in for a select line, which the port lacks
  input wire logic clear_i,
  input wire logic pha_i,
  input wire logic lsb_first_i,
  input wire logic [7:0] reply_i,
  // observed results
  output logic [7:0] got_o,
  output int frames_o
);
  int edges = 0; // clock edges seen in the current frame
  int k; // index of the reply bit on the line
  initial begin
    got_o = 8'h00;
    frames_o = 0;
  end
  // sample on one edge kind, count sixteen edges per frame
  always @(sck_i or posedge clear_i) begin
    if (clear_i) begin
      edges = 0;
    end else begin
      if ((edges % 2 == 1) == pha_i) begin
        got_o = lsb_first_i ? {mosi_i, got_o[7:1]} : {got_o[6:0], mosi_i};
      end
      edges = edges + 1;
      if (edges == 16) begin
        edges = 0;
        frames_o = frames_o + 1;
      end
    end
  end
  // reply bit moves on setup edges; between frames the line shows no stale bit
  always_comb begin
    k = pha_i ? (edges - 1) / 2 : edges / 2;
    if (pha_i && edges == 0) begin
      miso_o = ~reply_i[lsb_first_i ? 3'h0 : 3'h7];
    end else begin
      miso_o = reply_i[lsb_first_i ? k[2:0] : 3'h7 - k[2:0]];
    end
  end
endmodule : usm_spi_slave_model

// ---- verif/usm_port_tb_top.sv ----
// usm_port_tb_top: self-checking bench for the master-mode serial port
`timescale 1ns/10ps
module usm_port_tb_top;
  import usm_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic hsel = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, d;
  logic hreadyout, hresp, sck, dout, dout_oe, din, rx_owned;
  logic clr = 1'b1; // clears the far side's edge count
  logic pha = 1'b0, lsb = 1'b0, sck_q = 1'b0;
  logic [7:0] reply = 8'h00, got;
  int frames, n0, fails = 0, num_checks = 0, gap = 0, cnt = 0;
  always #50 clock_i = ~clock_i;
  usm_port usm_port_inst (.clock_i(clock_i), .rst_i(rst_i), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
    .hwdata_i(hwdata), .hready_i(hreadyout), .hrdata_o(hrdata), .hreadyout_o(hreadyout),
    .hresp_o(hresp), .serial_clock_pin_o(sck), .serial_data_out_pin_o(dout),
    .serial_data_out_pin_oe_o(dout_oe), .serial_data_in_pin_i(din),
    .serial_data_in_owned_o(rx_owned));
  usm_spi_slave_model usm_spi_slave_model_inst (.sck_i(sck), .mosi_i(dout), .miso_o(din),
    .clear_i(clr), .pha_i(pha), .lsb_first_i(lsb), .reply_i(reply), .got_o(got),
    .frames_o(frames));
  // measure system cycles between serial clock edges
  always @(posedge clock_i) begin
    sck_q <= sck;
    if (sck !== sck_q) begin
      gap <= cnt;
      cnt <= 1;
    end else begin
      cnt <= cnt + 1;
    end
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic complete_run();
    if (fails == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] seen);
    num_checks++;
    if (seen !== exp) begin
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      fails++;
    end
  endtask : chk
  // bounded wait for hready; a stuck bus ends the run
  task automatic hold_ready();
    int n;
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) begin
      fails++;
      complete_run();
    end
  endtask : hold_ready
  // one single word transfer; the trailing idle lets a read see a prior write
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= USM_HTRANS_NONSEQ;
    hold_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    hold_ready();
    d = hrdata;
    @(posedge clock_i);
  endtask : bus
  task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(name, e, d);
  endtask : rdchk
  // poll until the transmit-complete flag is up, then clear it
  task automatic wait_done();
    int n;
    n = 0;
    do begin
      bus(1'b0, USM_ADDR_STATUS, 32'h0);
      n++;
    end while (d[USM_ST_TXC] !== 1'b1 && n < 3000);
    if (d[USM_ST_TXC] !== 1'b1) begin
      fails++;
      complete_run();
    end
    bus(1'b1, USM_ADDR_STATUS, 32'h40);
  endtask : wait_done
  task automatic start(input logic [7:0] tx, input logic [7:0] rep);
    reply <= rep;
    clr <= 1'b1;
    @(posedge clock_i);
    clr <= 1'b0;
    bus(1'b1, USM_ADDR_DATA, {24'h0, tx});
  endtask : start
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clock_i);
    rst_i <= 1'b0;
    @(posedge clock_i);
    rdchk("status_reset", USM_ADDR_STATUS, 32'h20);
    rdchk("rate_lo_reset", USM_ADDR_RATE_LO, 32'h0);
    rdchk("rate_hi_reset", USM_ADDR_RATE_HI, 32'h0);
    rdchk("unmapped", 8'h3c, 32'h0);
    bus(1'b1, USM_ADDR_CTRL_B, 32'h18);
    start(8'h5a, 8'h00);
    repeat (40) @(posedge clock_i);
    chk("frames_wrong_mode", 32'h0, frames);
    bus(1'b1, USM_ADDR_CTRL_C, 32'hc0);
    bus(1'b1, USM_ADDR_RATE_HI, 32'h1);
    bus(1'b1, USM_ADDR_RATE_LO, 32'h2);
    start(8'h96, 8'h69);
    wait_done();
    chk("edge_gap", 32'd259, gap);
    rdchk("rx_slow", USM_ADDR_DATA, 32'h69);
    chk("slave_slow", 32'h96, {24'h0, got});
    bus(1'b1, USM_ADDR_RATE_HI, 32'h0);
    bus(1'b1, USM_ADDR_RATE_LO, 32'h0);
    for (int f = 0; f < 8; f++) begin
      pha <= f[1];
      lsb <= f[2];
      bus(1'b1, USM_ADDR_CTRL_C, 32'hc0 | 32'(f));
      start(8'hc3 ^ 8'(f), 8'h1e + 8'(f));
      wait_done();
      rdchk("status_done", USM_ADDR_STATUS, 32'ha0);
      rdchk("rx_byte", USM_ADDR_DATA, {24'h0, 8'h1e + 8'(f)});
      chk("slave_byte", {24'h0, 8'hc3 ^ 8'(f)}, {24'h0, got});
    end
    n0 = frames;
    start(8'h81, 8'h77);
    bus(1'b1, USM_ADDR_DATA, 32'h42);
    wait_done();
    chk("frames_pair", 32'(n0 + 2), frames);
    chk("line_idle", 32'h1, {31'h0, dout});
    rdchk("rx_pair_a", USM_ADDR_DATA, 32'h77);
    rdchk("rx_pair_b", USM_ADDR_DATA, 32'h77);
    for (int i = 1; i < 4; i++) begin
      start(8'(i), 8'(i * 17));
      wait_done();
    end
    rdchk("rx_keep_first", USM_ADDR_DATA, 32'h11);
    rdchk("rx_keep_second", USM_ADDR_DATA, 32'h22);
    rdchk("rx_empty", USM_ADDR_STATUS, 32'h20);
    n0 = frames;
    start(8'h3c, 8'h55);
    bus(1'b1, USM_ADDR_CTRL_B, 32'h10);
    wait_done();
    chk("frames_drain", 32'(n0 + 1), frames);
    chk("pin_released", 32'h0, {31'h0, dout_oe});
    start(8'h99, 8'h00);
    repeat (40) @(posedge clock_i);
    chk("frames_rx_only", 32'(n0 + 1), frames);
    bus(1'b1, USM_ADDR_CTRL_B, 32'h0);
    rdchk("rx_flushed", USM_ADDR_STATUS, 32'h20);
    complete_run();
  end
endmodule : usm_port_tb_top
